// file: inc/lcr_cfg.svh
// Timing, framing and protocol constants for the bus capture unit
`ifndef LCR_CFG_SVH
`define LCR_CFG_SVH

`define LCR_CLK_HZ        20000000
`define LCR_BAUD_1200     1200
`define LCR_BAUD_2400     2400
`define LCR_BAUD_4800     4800
`define LCR_BAUD_9600     9600
`define LCR_BAUD_10400    10400
`define LCR_BAUD_19200    19200
`define LCR_BAUD_20000    20000
`define LCR_BAUD_SEL_DEF  3'h5
`define LCR_BIT_CYC(b)    ((`LCR_CLK_HZ + (b) / 2) / (b))
`define LCR_CHAR_BITS     10
`define LCR_TIMEOUT_CHARS 3
`define LCR_BLOCK_MAX     10
`define LCR_BREAK_BITS    13
`define LCR_SYNC_BYTE     8'h55
`define LCR_DIAG_ID_MIN   6'h3C
`define LCR_WAKE_MIN_US   250
`define LCR_WAKE_MAX_US   5000
`define LCR_CYC_PER_US    (`LCR_CLK_HZ / 1000000)
`define LCR_STAMP_W       32

`endif

// file: inc/lcr_pkg.sv
// Types shared by the bus capture unit
package lcr_pkg;
  `include "lcr_cfg.svh"

  typedef enum logic [1:0] {
    KIND_FRAME    = 2'h0,
    KIND_CSUM_ERR = 2'h1,
    KIND_ERR_BLK  = 2'h2,
    KIND_WAKEUP   = 2'h3
  } lcr_kind_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SYNC = 5'h02,
    ST_PID  = 5'h04,
    ST_DATA = 5'h08,
    ST_CSUM = 5'h10
  } lcr_state_t;

  typedef struct packed {
    lcr_kind_t                kind;
    logic [7:0]               pid;
    logic [3:0]               len;
    logic [9:0][7:0]          data;
    logic                     parityOk;
    logic                     headerOk;
    logic                     csumOk;
    logic [`LCR_STAMP_W-1:0]  stamp;
  } lcr_rec_t;
endpackage

// file: design/lcr_byte_rx.sv
// Character receiver with configured bit-rate divider
`timescale 1ns/1ns
`include "lcr_cfg.svh"

module lcr_byte_rx #(
  parameter int CYC_W  = 15,
  parameter int CLK_HZ = `LCR_CLK_HZ
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Synchronised line and rate selection
  input  wire logic             rxLine,
  input  wire logic [2:0]       baudSel,
  // Received character
  output logic                  byteValid,
  output logic [7:0]            byteData,
  output logic                  stopErr,
  // Bit timing
  output logic                  bitTick,
  output logic [CYC_W-1:0]      bitCycles
);

  logic [CYC_W-1:0] cycLookup;
  logic [CYC_W-1:0] tickCnt_reg;
  logic [CYC_W-1:0] smpCnt_reg;
  logic [3:0]       bitIdx_reg;
  logic             active_reg;
  logic             prevLine_reg;
  logic [7:0]       shift_reg;

  // Rounded clock cycles per bit
  function automatic logic [CYC_W-1:0] bitCyc(input int baud);
    return CYC_W'((CLK_HZ + baud / 2) / baud);
  endfunction

  // ----------------------------------------
  // Rate lookup, from configuration only
  // ----------------------------------------
  always_comb begin
    unique case (baudSel)
      3'h0: cycLookup = bitCyc(`LCR_BAUD_1200);
      3'h1: cycLookup = bitCyc(`LCR_BAUD_2400);
      3'h2: cycLookup = bitCyc(`LCR_BAUD_4800);
      3'h3: cycLookup = bitCyc(`LCR_BAUD_9600);
      3'h4: cycLookup = bitCyc(`LCR_BAUD_10400);
      3'h5: cycLookup = bitCyc(`LCR_BAUD_19200);
      3'h6: cycLookup = bitCyc(`LCR_BAUD_20000);
      default: cycLookup = bitCyc(`LCR_BAUD_19200);
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bitCycles <= bitCyc(`LCR_BAUD_19200);
    end else begin
      bitCycles <= cycLookup;
    end
  end

  // ----------------------------------------
  // Free-running bit period enable
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tickCnt_reg <= '0;
      bitTick     <= 1'b0;
    end else if (tickCnt_reg >= bitCycles - CYC_W'(1)) begin
      tickCnt_reg <= '0;
      bitTick     <= 1'b1;
    end else begin
      tickCnt_reg <= tickCnt_reg + CYC_W'(1);
      bitTick     <= 1'b0;
    end
  end

  // ----------------------------------------
  // Character sampling at bit centres
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      active_reg   <= 1'b0;
      prevLine_reg <= 1'b1;
      smpCnt_reg   <= '0;
      bitIdx_reg   <= 4'h0;
      shift_reg    <= 8'h00;
      byteValid    <= 1'b0;
      byteData     <= 8'h00;
      stopErr      <= 1'b0;
    end else begin
      prevLine_reg <= rxLine;
      byteValid    <= 1'b0;
      if (!active_reg) begin
        if (prevLine_reg && !rxLine) begin
          active_reg <= 1'b1;
          smpCnt_reg <= bitCycles >> 1;
          bitIdx_reg <= 4'h0;
        end
      end else if (smpCnt_reg != '0) begin
        smpCnt_reg <= smpCnt_reg - CYC_W'(1);
      end else begin
        smpCnt_reg <= bitCycles - CYC_W'(1);
        bitIdx_reg <= bitIdx_reg + 4'h1;
        if (bitIdx_reg == 4'h0 && rxLine) begin
          active_reg <= 1'b0;
        end else if (bitIdx_reg == 4'h9) begin
          active_reg <= 1'b0;
          byteValid  <= 1'b1;
          byteData   <= shift_reg;
          stopErr    <= ~rxLine;
        end else if (bitIdx_reg != 4'h0) begin
          shift_reg <= {rxLine, shift_reg[7:1]};
        end
      end
    end
  end

endmodule

// file: design/lcr_capture.sv
// Passive single-wire bus capture unit producing message records
// ----------------------------------------
// Summary of operation
// - Listen only, never drive the line
// - Seven selectable bit rates, 1200 to 20000
// - Bit rate from configuration, no detection
// - Check parity, header format, checksum; report
// - Decode protocol revisions 1.3, 2.0, 2.1
// - Time stamp taken at message end
// - Headerless bytes grouped, block closes at ten
// - Open block closes after three-character silence
// - Distinct records for wakeups and checksum errors
// ----------------------------------------
`timescale 1ns/1ns
`include "lcr_cfg.svh"

module lcr_capture #(
  parameter int CYC_W       = 15,
  parameter int LOW_W       = 20,
  parameter int CLK_HZ      = `LCR_CLK_HZ,
  parameter int WAKE_MIN_CYC = `LCR_WAKE_MIN_US * `LCR_CYC_PER_US,
  parameter int WAKE_MAX_CYC = `LCR_WAKE_MAX_US * `LCR_CYC_PER_US
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Bus pin
  input  wire logic         linRx,
  output logic              linTx,
  output logic              linTxOen,
  // Configuration
  input  wire logic [2:0]   baudSel,
  input  wire logic         enhancedCsum,
  // Record stream
  output logic              recValid,
  output lcr_pkg::lcr_rec_t rec
);

  localparam logic [5:0] TMO_BITS = 6'(`LCR_TIMEOUT_CHARS * `LCR_CHAR_BITS);

  logic                   rxMeta_reg;
  logic                   rxSync_reg;
  logic                   rxPrev_reg;
  logic                   byteValid;
  logic [7:0]             byteData;
  logic                   stopErr;
  logic                   bitTick;
  logic [CYC_W-1:0]       bitCycles;
  logic [`LCR_STAMP_W-1:0] stamp_reg;
  logic [5:0]             idleBits_reg;
  logic                   timeout;
  logic [LOW_W-1:0]       lowCnt_reg;
  logic [LOW_W-1:0]       breakCyc;
  logic                   wakeEvt;
  logic                   isBreak;
  lcr_pkg::lcr_state_t    state_reg;
  logic [3:0]             cnt_reg;
  logic [3:0]             len_reg;
  logic [7:0]             pid_reg;
  logic [7:0]             sum_reg;
  logic                   parOk_reg;
  logic                   fmtOk_reg;
  logic                   errOpen_reg;
  logic [9:0][7:0]        buf_reg;
  logic [9:0][7:0]        bufNext;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] csumAdd(input logic [7:0] a,
                                         input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  function automatic logic pidParity(input logic [7:0] p);
    logic p0;
    logic p1;
    p0 = p[0] ^ p[1] ^ p[2] ^ p[4];
    p1 = ~(p[1] ^ p[3] ^ p[4] ^ p[5]);
    return (p[6] == p0) && (p[7] == p1);
  endfunction

  function automatic logic [3:0] pidLen(input logic [7:0] p);
    unique case (p[5:4])
      2'h2:    return 4'h4;
      2'h3:    return 4'h8;
      default: return 4'h2;
    endcase
  endfunction

  // ----------------------------------------
  // Line output, permanently released
  // ----------------------------------------
  always_ff @(posedge clk) begin
    linTx    <= 1'b1;
    linTxOen <= 1'b1;
  end

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rxMeta_reg <= 1'b1;
      rxSync_reg <= 1'b1;
      rxPrev_reg <= 1'b1;
    end else begin
      rxMeta_reg <= linRx;
      rxSync_reg <= rxMeta_reg;
      rxPrev_reg <= rxSync_reg;
    end
  end

  lcr_byte_rx #(
    .CYC_W (CYC_W),
    .CLK_HZ(CLK_HZ)
  ) u_rx (
    .clk      (clk),
    .rst      (rst),
    .rxLine   (rxSync_reg),
    .baudSel  (baudSel),
    .byteValid(byteValid),
    .byteData (byteData),
    .stopErr  (stopErr),
    .bitTick  (bitTick),
    .bitCycles(bitCycles)
  );

  assign isBreak = byteValid && byteData == 8'h00 && stopErr;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      stamp_reg <= '0;
    end else begin
      stamp_reg <= stamp_reg + `LCR_STAMP_W'(1);
    end
  end

  // ----------------------------------------
  // Inter-character silence
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst || byteValid) begin
      idleBits_reg <= 6'h00;
    end else if (bitTick && idleBits_reg != TMO_BITS) begin
      idleBits_reg <= idleBits_reg + 6'h01;
    end
  end

  assign timeout = !byteValid && bitTick
                   && idleBits_reg == TMO_BITS - 6'h01;

  // ----------------------------------------
  // Wakeup pulse measurement
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst || rxSync_reg) begin
      lowCnt_reg <= '0;
    end else if (lowCnt_reg != '1) begin
      lowCnt_reg <= lowCnt_reg + LOW_W'(1);
    end
  end

  assign breakCyc = LOW_W'(bitCycles) * LOW_W'(`LCR_BREAK_BITS);
  assign wakeEvt  = rxSync_reg && !rxPrev_reg
                    && lowCnt_reg >= LOW_W'(WAKE_MIN_CYC)
                    && lowCnt_reg <= LOW_W'(WAKE_MAX_CYC)
                    && lowCnt_reg < breakCyc;

  always_comb begin
    bufNext          = buf_reg;
    bufNext[cnt_reg] = byteData;
  end

  // ----------------------------------------
  // Frame decoding, error blocks, records
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg   <= lcr_pkg::ST_IDLE;
      cnt_reg     <= 4'h0;
      len_reg     <= 4'h0;
      pid_reg     <= 8'h00;
      sum_reg     <= 8'h00;
      parOk_reg   <= 1'b0;
      fmtOk_reg   <= 1'b0;
      errOpen_reg <= 1'b0;
      buf_reg     <= '0;
      recValid    <= 1'b0;
      rec         <= '0;
    end else begin
      recValid <= 1'b0;
      if (isBreak) begin
        if (errOpen_reg) begin
          recValid      <= 1'b1;
          rec.kind      <= lcr_pkg::KIND_ERR_BLK;
          rec.len       <= cnt_reg;
          rec.data      <= buf_reg;
          rec.parityOk  <= 1'b0;
          rec.headerOk  <= 1'b0;
          rec.csumOk    <= 1'b0;
          rec.stamp     <= stamp_reg;
        end
        errOpen_reg <= 1'b0;
        cnt_reg     <= 4'h0;
        state_reg   <= lcr_pkg::ST_SYNC;
      end else if (byteValid) begin
        unique case (state_reg)
          lcr_pkg::ST_IDLE: begin
            buf_reg <= bufNext;
            if (cnt_reg == 4'(`LCR_BLOCK_MAX - 1)) begin
              recValid     <= 1'b1;
              rec.kind     <= lcr_pkg::KIND_ERR_BLK;
              rec.len      <= 4'(`LCR_BLOCK_MAX);
              rec.data     <= bufNext;
              rec.parityOk <= 1'b0;
              rec.headerOk <= 1'b0;
              rec.csumOk   <= 1'b0;
              rec.stamp    <= stamp_reg;
              cnt_reg      <= 4'h0;
              errOpen_reg  <= 1'b0;
            end else begin
              cnt_reg     <= cnt_reg + 4'h1;
              errOpen_reg <= 1'b1;
            end
          end
          lcr_pkg::ST_SYNC: begin
            if (byteData == `LCR_SYNC_BYTE && !stopErr) begin
              state_reg <= lcr_pkg::ST_PID;
            end else begin
              buf_reg[0]  <= byteData;
              cnt_reg     <= 4'h1;
              errOpen_reg <= 1'b1;
              state_reg   <= lcr_pkg::ST_IDLE;
            end
          end
          lcr_pkg::ST_PID: begin
            pid_reg   <= byteData;
            parOk_reg <= pidParity(byteData);
            fmtOk_reg <= !stopErr;
            len_reg   <= pidLen(byteData);
            sum_reg   <= (enhancedCsum
                          && byteData[5:0] < `LCR_DIAG_ID_MIN)
                         ? byteData : 8'h00;
            cnt_reg   <= 4'h0;
            state_reg <= lcr_pkg::ST_DATA;
          end
          lcr_pkg::ST_DATA: begin
            buf_reg   <= bufNext;
            sum_reg   <= csumAdd(sum_reg, byteData);
            fmtOk_reg <= fmtOk_reg && !stopErr;
            cnt_reg   <= cnt_reg + 4'h1;
            if (cnt_reg == len_reg - 4'h1) begin
              state_reg <= lcr_pkg::ST_CSUM;
            end
          end
          lcr_pkg::ST_CSUM: begin
            recValid     <= 1'b1;
            rec.kind     <= (csumAdd(sum_reg, byteData) == 8'hFF)
                            ? lcr_pkg::KIND_FRAME
                            : lcr_pkg::KIND_CSUM_ERR;
            rec.pid      <= pid_reg;
            rec.len      <= len_reg;
            rec.data     <= buf_reg;
            rec.parityOk <= parOk_reg;
            rec.headerOk <= fmtOk_reg && !stopErr;
            rec.csumOk   <= csumAdd(sum_reg, byteData) == 8'hFF;
            rec.stamp    <= stamp_reg;
            cnt_reg      <= 4'h0;
            state_reg    <= lcr_pkg::ST_IDLE;
          end
          default: begin
            cnt_reg   <= 4'h0;
            state_reg <= lcr_pkg::ST_IDLE;
          end
        endcase
      end else if (timeout) begin
        if (errOpen_reg) begin
          recValid     <= 1'b1;
          rec.kind     <= lcr_pkg::KIND_ERR_BLK;
          rec.len      <= cnt_reg;
          rec.data     <= buf_reg;
          rec.parityOk <= 1'b0;
          rec.headerOk <= 1'b0;
          rec.csumOk   <= 1'b0;
          rec.stamp    <= stamp_reg;
        end
        errOpen_reg <= 1'b0;
        cnt_reg     <= 4'h0;
        state_reg   <= lcr_pkg::ST_IDLE;
      end else if (wakeEvt && state_reg == lcr_pkg::ST_IDLE
                   && !errOpen_reg) begin
        recValid     <= 1'b1;
        rec.kind     <= lcr_pkg::KIND_WAKEUP;
        rec.len      <= 4'h0;
        rec.parityOk <= 1'b0;
        rec.headerOk <= 1'b0;
        rec.csumOk   <= 1'b0;
        rec.stamp    <= stamp_reg;
      end
    end
  end

endmodule

// file: tb/lcr_capture_asserts.sv
// Concurrent checks on the bus capture unit ports
`timescale 1ns/1ns

module lcr_capture_asserts (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Bus pin
  input wire logic              linRx,
  input wire logic              linTx,
  input wire logic              linTxOen,
  // Configuration
  input wire logic [2:0]        baudSel,
  input wire logic              enhancedCsum,
  // Record stream
  input wire logic              recValid,
  input wire lcr_pkg::lcr_rec_t rec
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic frm;
  logic blk;
  assign frm = recValid && (rec.kind == lcr_pkg::KIND_FRAME
    || rec.kind == lcr_pkg::KIND_CSUM_ERR);
  assign blk = recValid && rec.kind == lcr_pkg::KIND_ERR_BLK;

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_line_released: assert property (linTxOen && linTx)
    else $error("bus pin driven");
  a_pin_steady: assert property ($stable(linTxOen) && $stable(linTx))
    else $error("bus pin changed");
  a_rec_holds: assert property (!recValid |-> $stable(rec))
    else $error("record changed without valid");
  a_pulse_single: assert property (recValid |=> !recValid)
    else $error("record valid longer than one cycle");
  a_block_size: assert property (blk |-> rec.len inside {[1:10]})
    else $error("error block length out of range");
  a_wake_empty: assert property (recValid &&
    rec.kind == lcr_pkg::KIND_WAKEUP |-> rec.len == 4'h0)
    else $error("wakeup record not empty");
  a_wake_edge: assert property (recValid &&
    rec.kind == lcr_pkg::KIND_WAKEUP |-> $past(linRx, 3) && !$past(linRx, 4))
    else $error("wakeup record not after line release");
  a_csum_kind: assert property (frm |->
    (rec.kind == lcr_pkg::KIND_CSUM_ERR) == !rec.csumOk)
    else $error("checksum kind and flag disagree");
  a_frame_len: assert property (frm |-> rec.len ==
    (rec.pid[5] ? (rec.pid[4] ? 4'h8 : 4'h4) : 4'h2))
    else $error("frame length does not follow identifier");
  a_parity_flag: assert property (frm |-> rec.parityOk ==
    (rec.pid[6] == ^{rec.pid[0], rec.pid[1], rec.pid[2], rec.pid[4]}
    && rec.pid[7] == ~^{rec.pid[1], rec.pid[3], rec.pid[4], rec.pid[5]}))
    else $error("parity flag wrong");
endmodule

// file: tb/lcr_lin_node.sv
// Behavioural bus node driving characters onto the line
`timescale 1ns/1ns

module lcr_lin_node (
  // Clock
  input wire logic clk,
  // Bus line, recessive high
  output logic     line
);
  int bitCyc = 100;

  initial line = 1'b1;

  // Drives one bit period
  task automatic putBit(input logic v);
    @(posedge clk);
    line <= v;
    repeat (bitCyc - 1) @(posedge clk);
  endtask

  // Start bit, LSB first data, stop bit
  task automatic sendByte(input logic [7:0] b);
    putBit(1'b0);
    for (int i = 0; i < 8; i++) begin
      putBit(b[i]);
    end
    putBit(1'b1);
  endtask

  // Thirteen dominant bits and a delimiter
  task automatic sendBreak();
    repeat (13) putBit(1'b0);
    putBit(1'b1);
  endtask

  // Low pulse of a given cycle count
  task automatic pulseLow(input int cyc);
    @(posedge clk);
    line <= 1'b0;
    repeat (cyc) @(posedge clk);
    line <= 1'b1;
  endtask
endmodule

// file: tb/lcr_capture_tb_top.sv
// Self-checking bench for the bus capture unit
`timescale 1ns/1ns

module lcr_capture_tb_top;
  logic              clk = 1'b0;
  logic              rst;
  logic              linRx;
  logic              linTx;
  logic              linTxOen;
  logic [2:0]        baudSel;
  logic              enhancedCsum;
  logic              recValid;
  lcr_pkg::lcr_rec_t rec;
  lcr_pkg::lcr_rec_t r;
  lcr_pkg::lcr_rec_t recQ[$];
  int                cycQ[$];
  int                cyc = 0;
  int                rcyc;
  int                lastCyc = 0;
  logic [31:0]       lastStamp;
  int                failures = 0;
  int                total_checks = 0;

  always #25 clk = ~clk;

  lcr_lin_node node (.clk(clk), .line(linRx));

  // Scaled clock rate keeps bit periods short
  lcr_capture #(.CLK_HZ(2000000), .WAKE_MIN_CYC(20), .WAKE_MAX_CYC(40)) uut (
    .clk(clk), .rst(rst), .linRx(linRx), .linTx(linTx),
    .linTxOen(linTxOen), .baudSel(baudSel),
    .enhancedCsum(enhancedCsum), .recValid(recValid), .rec(rec));

  // ----------------------------------------
  // Record capture and run limit
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (recValid === 1'b1) begin
      recQ.push_back(rec);
      cycQ.push_back(cyc);
    end
    if (cyc == 60000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [131:0] seen, input logic [131:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic popRec(input int lim);
    for (int i = 0; i < lim && recQ.size() == 0; i++)
      @(posedge clk);
    check(recQ.size() > 0, 1'b1);
    r = recQ.size() > 0 ? recQ.pop_front() : '0;
    rcyc = cycQ.size() > 0 ? cycQ.pop_front() : 0;
    if (lastCyc > 0)
      check(r.stamp - lastStamp, 32'(rcyc - lastCyc));
    lastCyc = rcyc;
    lastStamp = r.stamp;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check({linTx, linTxOen, recValid}, 3'b110);
    check(rec, '0);
    $display("t_reset done");
  endtask

  task automatic t_frame(input logic [5:0] id, input logic [15:0] d,
                         input logic bad);
    logic [7:0] pid;
    logic [8:0] s;
    int         t0;
    pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4],
           id};
    s = enhancedCsum ? {1'b0, pid} : 9'h000;
    for (int i = 0; i < 2; i++) begin
      s = s + d[8*i +: 8];
      s = s[7:0] + s[8];
    end
    node.sendBreak();
    node.sendByte(8'h55);
    node.sendByte(pid);
    node.sendByte(d[7:0]);
    node.sendByte(d[15:8]);
    t0 = cyc;
    node.sendByte(~s[7:0] ^ {7'h00, bad});
    popRec(10);
    check(r.kind, bad ? lcr_pkg::KIND_CSUM_ERR : lcr_pkg::KIND_FRAME);
    check({r.pid, r.len, r.parityOk, r.headerOk, r.csumOk},
          {pid, 4'h2, 2'b11, ~bad});
    check(r.data[1:0], d);
    check(rcyc - t0 >= 900 && rcyc - t0 <= 1000, 1'b1);
    $display("t_frame done");
  endtask

  task automatic t_block10();
    logic [9:0][7:0] e;
    for (int i = 0; i < 10; i++) begin
      e[i] = 8'(8'hA0 + i);
      check(recQ.size(), 0);
      node.sendByte(e[i]);
    end
    popRec(1);
    check({r.kind, r.len, r.data}, {lcr_pkg::KIND_ERR_BLK, 4'hA, e});
    $display("t_block10 done");
  endtask

  task automatic t_timeout();
    int t0;
    baudSel <= 3'h5;
    node.bitCyc = 104;
    repeat (4) @(posedge clk);
    node.sendByte(8'h3C);
    node.sendByte(8'h00);
    node.sendByte(8'hC3);
    t0 = cyc;
    popRec(32 * 104);
    check(r.kind, lcr_pkg::KIND_ERR_BLK);
    check({r.len, r.data[2:0]}, {4'h3, 24'hC3003C});
    check(rcyc - t0 >= 28 * 104 && rcyc - t0 <= 31 * 104, 1'b1);
    $display("t_timeout done");
  endtask

  task automatic t_wakeup();
    node.pulseLow(10);
    repeat (300) @(posedge clk);
    check(recQ.size(), 0);
    node.pulseLow(30);
    popRec(20);
    check({r.kind, r.len}, {lcr_pkg::KIND_WAKEUP, 4'h0});
    check({linTx, linTxOen}, 2'b11);
    $display("t_wakeup done");
  endtask

  task automatic t_midreset();
    node.sendByte(8'h12);
    node.sendByte(8'h34);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    check({recValid, rec}, '0);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    node.sendByte(8'h5A);
    lastCyc = 0;
    popRec(35 * 104);
    check({r.kind, r.len, r.data[0]},
          {lcr_pkg::KIND_ERR_BLK, 4'h1, 8'h5A});
    check(recQ.size(), 0);
    $display("t_midreset done");
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst          <= 1'b1;
    baudSel      <= 3'h6;
    enhancedCsum <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    t_reset();
    t_frame(6'h11, 16'h8134, 1'b0);
    enhancedCsum <= 1'b0;
    @(posedge clk);
    t_frame(6'h0A, 16'hFF7E, 1'b1);
    t_frame(6'h05, 16'h1234, 1'b0);
    t_block10();
    t_timeout();
    t_wakeup();
    t_midreset();
    tally_and_finish();
  end
endmodule

bind lcr_capture lcr_capture_asserts chk (
  .clk(clk), .rst(rst), .linRx(linRx), .linTx(linTx),
  .linTxOen(linTxOen), .baudSel(baudSel),
  .enhancedCsum(enhancedCsum), .recValid(recValid), .rec(rec));
